// ### rtl/bbp_defs.svh
`ifndef BBP_DEFS_SVH
`define BBP_DEFS_SVH
// bit-mode command values
`define BBP_CMD_RESET     8'h00
`define BBP_CMD_ASYNC     8'h01
`define BBP_CMD_SYNC      8'h04
// base channel modes
`define BBP_BASE_FIFO     2'h0
`define BBP_BASE_UART     2'h1
`define BBP_BASE_OPTO     2'h2
// reset values
`define BBP_DIR_RST       8'h00
`define BBP_DATA_RST      8'hff
// bit-bang access phase length in ns, rounded up to whole core clocks
`define BBP_PHASE_NS      50
`define BBP_CLK_NS        25
`define BBP_PHASE_CYC     ((`BBP_PHASE_NS + `BBP_CLK_NS - 1) / `BBP_CLK_NS)
`endif

// ### rtl/bbp_pkg.sv
`default_nettype none
package bbp_pkg;
  typedef enum logic [2:0] {
    BBP_IDLE,
    BBP_SAMPLE,
    BBP_RD_OFF,
    BBP_RD_ON,
    BBP_SETUP,
    BBP_WR_ON,
    BBP_WR_OFF
  } bbp_state_t;
endpackage : bbp_pkg
`default_nettype wire

// ### rtl/bbp_link_if.sv
`default_nettype none
interface bbp_link_if;
  logic [7:0] bus_out;      // device drive value
  logic [7:0] bus_oe;       // device drive enable, high = driving
  logic [7:0] far_out;      // far-end drive value
  logic [7:0] far_oe;       // far-end drive enable
  logic       wr_strobe_a_n;
  logic       rd_strobe_a_n;
  logic       wr_strobe_b_n;
  logic       rd_strobe_b_n;
  logic       send_now_wake_in;
  logic       power_enable_out_n;
  logic [7:0] bus_level;
  // resolved level: each line driven by one side, else pulled high
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      bus_level[i] = bus_oe[i] ? bus_out[i] : (far_oe[i] ? far_out[i] : 1'b1);
    end
  end
  modport dev (output bus_out, bus_oe, wr_strobe_a_n, rd_strobe_a_n, wr_strobe_b_n, rd_strobe_b_n,
               power_enable_out_n, input bus_level, send_now_wake_in);
  modport far (output far_out, far_oe, send_now_wake_in,
               input bus_level, wr_strobe_a_n, rd_strobe_a_n, wr_strobe_b_n, rd_strobe_b_n, power_enable_out_n);
endinterface : bbp_link_if
`default_nettype wire

// ### rtl/bbp_far_end.sv
`include "bbp_defs.svh"
`default_nettype none
// external logic that captures on the bit-bang write strobe; drives inputs lines
module bbp_far_end
  import bbp_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset,
  bbp_link_if.far         link,
  input  wire logic [7:0] drive_value,
  input  wire logic [7:0] drive_enable,
  input  wire logic       send_now_req,
  output logic [7:0]      captured_byte,
  output logic            captured_valid,
  output logic            suspended
);
  typedef struct packed {
    logic [1:0] wr_sync;
    logic [1:0] pwr_sync;
    logic       wr_prev;
    logic [7:0] cap;
    logic       cap_vld;
    logic [7:0] out;
    logic [7:0] oe;
    logic       wake_n;
  } bbp_far_st_t;
  bbp_far_st_t st_ff, nxt_st;

  // strobe taken through two flops; capture on rising edge (strobe end) [R18]
  always_comb begin
    logic wr_any;
    wr_any = link.wr_strobe_a_n & link.wr_strobe_b_n;
    nxt_st          = st_ff;
    nxt_st.wr_sync  = {st_ff.wr_sync[0], wr_any};
    nxt_st.pwr_sync = {st_ff.pwr_sync[0], link.power_enable_out_n};
    nxt_st.wr_prev  = st_ff.wr_sync[1];
    nxt_st.cap_vld  = 1'b0;
    if (st_ff.wr_sync[1] && !st_ff.wr_prev) begin
      nxt_st.cap     = link.bus_level;  // device holds data after strobe
      nxt_st.cap_vld = 1'b1;
    end
    nxt_st.out    = drive_value;
    nxt_st.oe     = drive_enable;
    nxt_st.wake_n = ~send_now_req;      // low strobe requests flush or wake [R16] [R17]
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_ff <= '{wr_sync: 2'h3, pwr_sync: 2'h0, wr_prev: 1'b1, cap: 8'h00, cap_vld: 1'b0,
                 out: 8'h00, oe: 8'h00, wake_n: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign link.far_out          = st_ff.out;
  assign link.far_oe           = st_ff.oe;
  assign link.send_now_wake_in = st_ff.wake_n;
  assign captured_byte         = st_ff.cap;
  assign captured_valid        = st_ff.cap_vld;
  assign suspended             = st_ff.pwr_sync[1];
endmodule : bbp_far_end
`default_nettype wire

// ### rtl/bbp_device.sv
`include "bbp_defs.svh"
`default_nettype none
// Summary of operation
// [R1] - bit-bang turns eight lines into bus
// [R2] - each line separately input or output
// [R3] - async mode drives host bytes per baud
// [R4] - async outputs change on new byte plus tick
// [R5] - host keeps baud below one megabaud
// [R6] - command 1 async, 0 back to reset
// [R7] - command 4 selects synchronous mode
// [R8] - sync drives only with sample space free
// [R9] - sync samples pins before each new byte
// [R10] - host sends extra byte for last sample
// [R11] - sample, rd off, rd on, setup, wr
// [R12] - async strobes brought out on pins
// [R13] - fifo or opto base uses first pair
// [R14] - uart base uses second pair
// [R15] - no bit-bang on channel b opto
// [R16] - suspended low strobe requests bus resume
// [R17] - running low strobe flushes transmit data
// [R18] - one write strobe per async byte
module bbp_device
  import bbp_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset,
  bbp_link_if.dev         link,
  input  wire logic       mode_cmd_valid,
  input  wire logic [7:0] mode_cmd,
  input  wire logic [7:0] dir_mask,
  input  wire logic [1:0] base_mode,
  input  wire logic       is_channel_b,
  input  wire logic       baud_tick,
  input  wire logic       usb_suspended,
  input  wire logic       remote_wake_en,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_byte,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic [7:0]      rx_byte,
  output logic            resume_req,
  output logic            flush_req,
  output logic            async_active,
  output logic            sync_active
);
  localparam logic [2:0] PHASE_CYC = 3'(`BBP_PHASE_CYC);

  typedef struct packed {
    logic       async_en;
    logic       sync_en;
    logic [7:0] dir;
    logic [7:0] data;
    logic [7:0] pend;
    logic       pend_vld;
    bbp_state_t state;
    logic [2:0] cnt;
    logic       rd_n;
    logic       wr_n;
    logic [7:0] rx;
    logic       rx_vld;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [1:0] wake_s;
    logic       wake_prev;
    logic       resume;
    logic       flush;
    logic       tx_rdy;
    logic       strobe_a;
    logic       strobe_b;
    logic       pwr_n;
    logic [7:0] oe;
    logic       wr_a_n;
    logic       rd_a_n;
    logic       wr_b_n;
    logic       rd_b_n;
  } bbp_dev_st_t;
  bbp_dev_st_t st_ff, nxt_st;

  // each phase after BBP_SAMPLE lasts PHASE_CYC clocks; BBP_SAMPLE takes one clock
  function automatic logic phase_done(input logic [2:0] c);
    phase_done = (c == PHASE_CYC - 3'h1);
  endfunction : phase_done

  always_comb begin
    logic allowed;
    logic wake_fall;
    allowed   = 1'b0;
    wake_fall = 1'b0;
    nxt_st = st_ff;
    // pins and wake input pass two flops before use
    nxt_st.pin_s1 = link.bus_level;
    nxt_st.pin_s2 = st_ff.pin_s1;
    nxt_st.wake_s = {st_ff.wake_s[0], link.send_now_wake_in};
    nxt_st.wake_prev = st_ff.wake_s[1];
    wake_fall = st_ff.wake_prev && !st_ff.wake_s[1];
    nxt_st.resume = wake_fall && usb_suspended && remote_wake_en;  // [R16]
    nxt_st.flush  = wake_fall && !usb_suspended;                   // [R17]
    nxt_st.pwr_n  = usb_suspended;
    // opto base on channel b blocks bit-bang entirely
    allowed = !(is_channel_b && base_mode == `BBP_BASE_OPTO);      // [R15]
    // mode command decode
    if (mode_cmd_valid) begin
      nxt_st.async_en = allowed && (mode_cmd == `BBP_CMD_ASYNC);   // [R6]
      nxt_st.sync_en  = allowed && (mode_cmd == `BBP_CMD_SYNC);    // [R7]
      if (mode_cmd == `BBP_CMD_RESET) begin                        // [R6]
        nxt_st.pend_vld = 1'b0;
        nxt_st.state    = BBP_IDLE;
        nxt_st.rd_n     = 1'b1;
        nxt_st.wr_n     = 1'b1;
      end
    end
    if (!allowed) begin
      nxt_st.async_en = 1'b0;
      nxt_st.sync_en  = 1'b0;
    end
    nxt_st.dir = dir_mask;                                         // [R2]
    // rx handshake: consumed byte frees the sample slot
    if (st_ff.rx_vld && rx_ready) begin
      nxt_st.rx_vld = 1'b0;
    end
    // accept host byte into the one-deep pending slot
    if (st_ff.tx_rdy && tx_valid) begin
      nxt_st.pend     = tx_byte;
      nxt_st.pend_vld = 1'b1;
    end
    nxt_st.cnt = phase_done(st_ff.cnt) ? 3'h0 : st_ff.cnt + 3'h1;
    case (st_ff.state)
      BBP_IDLE: begin
        nxt_st.cnt = 3'h0;
        if (st_ff.async_en && st_ff.pend_vld && baud_tick) begin   // [R3] [R4]
          nxt_st.data     = st_ff.pend;
          nxt_st.pend_vld = 1'b0;
          nxt_st.state    = BBP_SETUP;
        end else if (st_ff.sync_en && st_ff.pend_vld && !st_ff.rx_vld) begin // [R8]
          nxt_st.state = BBP_SAMPLE;
        end
      end
      BBP_SAMPLE: begin
        nxt_st.rx     = st_ff.pin_s2;                              // [R9] [R11]
        nxt_st.rx_vld = 1'b1;
        nxt_st.rd_n   = 1'b1;                                      // read off for the full phase [R11]
        nxt_st.state  = BBP_RD_OFF;
        nxt_st.cnt    = 3'h0;
      end
      BBP_RD_OFF: begin
        nxt_st.rd_n = 1'b1;                                        // [R11]
        if (phase_done(st_ff.cnt)) begin
          nxt_st.state    = BBP_RD_ON;
          nxt_st.rd_n     = 1'b0;
          nxt_st.data     = st_ff.pend;                            // outputs update [R11]
          nxt_st.pend_vld = 1'b0;
        end
      end
      BBP_RD_ON: begin
        if (phase_done(st_ff.cnt)) begin
          nxt_st.state = BBP_SETUP;
        end
      end
      BBP_SETUP: begin
        if (phase_done(st_ff.cnt)) begin
          nxt_st.state = BBP_WR_ON;
          nxt_st.wr_n  = 1'b0;                                     // [R11] [R18]
        end
      end
      BBP_WR_ON: begin
        if (phase_done(st_ff.cnt)) begin
          nxt_st.state = BBP_WR_OFF;
          nxt_st.wr_n  = 1'b1;                                     // [R11] [R18]
        end
      end
      BBP_WR_OFF: begin
        // hold time after strobe before the next byte may move the bus
        if (phase_done(st_ff.cnt)) begin
          nxt_st.state = BBP_IDLE;
        end
      end
      default: nxt_st.state = BBP_IDLE;
    endcase
    if (mode_cmd_valid && mode_cmd == `BBP_CMD_RESET) begin
      nxt_st.state = BBP_IDLE;
      nxt_st.wr_n  = 1'b1;
      nxt_st.rd_n  = 1'b1;
    end
    // slot refills only when it will be free next cycle
    nxt_st.tx_rdy = (st_ff.async_en | st_ff.sync_en) && !nxt_st.pend_vld && !(st_ff.tx_rdy && tx_valid);
    // route strobes to the pair chosen by base mode [R12] [R13] [R14]
    nxt_st.strobe_a = (base_mode != `BBP_BASE_UART);
    nxt_st.strobe_b = (base_mode == `BBP_BASE_UART);
    // pins built from the next state so they leave flops with no extra lag
    nxt_st.oe     = (nxt_st.async_en | nxt_st.sync_en) ? nxt_st.dir : 8'h00;  // [R1] [R2]
    nxt_st.wr_a_n = nxt_st.strobe_a ? nxt_st.wr_n : 1'b1;                      // [R13]
    nxt_st.rd_a_n = nxt_st.strobe_a ? nxt_st.rd_n : 1'b1;                      // [R13]
    nxt_st.wr_b_n = nxt_st.strobe_b ? nxt_st.wr_n : 1'b1;                      // [R14]
    nxt_st.rd_b_n = nxt_st.strobe_b ? nxt_st.rd_n : 1'b1;                      // [R14]
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_ff <= '{async_en: 1'b0, sync_en: 1'b0, dir: `BBP_DIR_RST, data: `BBP_DATA_RST, pend: 8'h00,
                 pend_vld: 1'b0, state: BBP_IDLE, cnt: 3'h0, rd_n: 1'b1, wr_n: 1'b1, rx: 8'h00,
                 rx_vld: 1'b0, pin_s1: 8'hff, pin_s2: 8'hff, wake_s: 2'h3, wake_prev: 1'b1,
                 resume: 1'b0, flush: 1'b0, tx_rdy: 1'b0, strobe_a: 1'b1, strobe_b: 1'b0,
                 pwr_n: 1'b0, oe: 8'h00, wr_a_n: 1'b1, rd_a_n: 1'b1, wr_b_n: 1'b1, rd_b_n: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // bus enabled only in a bit-bang mode, per-line direction [R1] [R2]
  assign link.bus_out            = st_ff.data;
  assign link.bus_oe             = st_ff.oe;
  assign link.wr_strobe_a_n      = st_ff.wr_a_n;
  assign link.rd_strobe_a_n      = st_ff.rd_a_n;
  assign link.wr_strobe_b_n      = st_ff.wr_b_n;
  assign link.rd_strobe_b_n      = st_ff.rd_b_n;
  assign link.power_enable_out_n = st_ff.pwr_n;
  assign tx_ready                = st_ff.tx_rdy;
  assign rx_valid                = st_ff.rx_vld;
  assign rx_byte                 = st_ff.rx;
  assign resume_req              = st_ff.resume;
  assign flush_req               = st_ff.flush;
  assign async_active            = st_ff.async_en;
  assign sync_active             = st_ff.sync_en;
endmodule : bbp_device
`default_nettype wire

// ### sim/bbp_link_asserts.sv
`default_nettype none
module bbp_link_asserts (
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic [7:0] bus_out,
  input wire logic       wr_strobe_a_n,
  input wire logic       rd_strobe_a_n,
  input wire logic       wr_strobe_b_n,
  input wire logic       rd_strobe_b_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle pair sits high, so and-ing merges the live pair into one view
  wire logic wr_n = wr_strobe_a_n & wr_strobe_b_n;
  wire logic rd_n = rd_strobe_a_n & rd_strobe_b_n;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // strobe phases, two clocks each
  sequence wr_pulse_s; !wr_n [*2] ##1 wr_n; endsequence
  sequence rd_gap_s; rd_n [*2] ##1 !rd_n; endsequence
  pair_excl_a: assert property ((wr_strobe_a_n && rd_strobe_a_n) || (wr_strobe_b_n && rd_strobe_b_n))
    else $error("both strobe pairs active");
  wr_width_a: assert property ($fell(wr_n) |-> wr_pulse_s)
    else $error("write strobe width wrong");
  wr_gap_a: assert property ($rose(wr_n) |-> wr_n [*2])
    else $error("write strobe recovery short");
  data_setup_a: assert property ($changed(bus_out) |-> wr_n ##1 wr_n)
    else $error("data changed too close to write strobe");
  data_hold_a: assert property (!wr_n |-> $stable(bus_out))
    else $error("data moved under write strobe");
  rd_gap_a: assert property ($rose(rd_n) |-> rd_gap_s)
    else $error("read strobe gap wrong");
  rd_quiet_a: assert property ($rose(rd_n) |-> $stable(bus_out) [*2])
    else $error("data moved before sample phase ended");
  rd_to_wr_a: assert property ($fell(rd_n) |-> wr_n [*4] ##1 !wr_n)
    else $error("write strobe not four clocks after read");
endmodule : bbp_link_asserts
`default_nettype wire

// ### sim/tb_bit_bang_parallel_port.sv
`include "bbp_defs.svh"
`default_nettype none
module tb_bit_bang_parallel_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk, reset, mode_cmd_valid, is_channel_b, baud_tick, usb_suspended, remote_wake_en;
  logic       tx_valid, rx_ready, send_now_req, tx_ready, rx_valid, resume_req, flush_req, sa, sb;
  logic       async_active, sync_active, captured_valid, suspended;
  logic [7:0] mode_cmd, dir_mask, tx_byte, rx_byte, drive_value, drive_enable, captured_byte, prev, b, e;
  logic [1:0] base_mode;
  logic [7:0] cmds [5] = '{`BBP_CMD_ASYNC, `BBP_CMD_SYNC, 8'h07, `BBP_CMD_RESET, `BBP_CMD_ASYNC};
  int         seed = 32'h13817129;
  int         fail_count = 0, checked = 0, cycles = 0, n;
  always #12.5 core_clk = ~core_clk;
  bbp_link_if bbp_link_if_i ();
  bbp_device bbp_device_i (.core_clk, .reset, .link(bbp_link_if_i), .mode_cmd_valid, .mode_cmd, .dir_mask,
    .base_mode, .is_channel_b, .baud_tick, .usb_suspended, .remote_wake_en, .tx_valid, .tx_ready, .tx_byte,
    .rx_valid, .rx_ready, .rx_byte, .resume_req, .flush_req, .async_active, .sync_active);
  bbp_far_end bbp_far_end_i (.core_clk, .reset, .link(bbp_link_if_i), .drive_value, .drive_enable,
    .send_now_req, .captured_byte, .captured_valid, .suspended);
  bbp_link_asserts bbp_link_asserts_i (.core_clk, .reset, .bus_out(bbp_link_if_i.bus_out),
    .wr_strobe_a_n(bbp_link_if_i.wr_strobe_a_n), .rd_strobe_a_n(bbp_link_if_i.rd_strobe_a_n),
    .wr_strobe_b_n(bbp_link_if_i.wr_strobe_b_n), .rd_strobe_b_n(bbp_link_if_i.rd_strobe_b_n));
  // expected pin level: own outputs, far drive, else pull-up
  function automatic logic [7:0] lvl(input logic [7:0] d, dir, fv, fe);
    return (d & dir) | (~dir & ((fv & fe) | ~fe));
  endfunction : lvl
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic set_mode(input logic [7:0] c);
    @(posedge core_clk);
    mode_cmd_valid <= 1'b1;
    mode_cmd <= c;
    @(posedge core_clk);
    mode_cmd_valid <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : set_mode
  // request held until the edge that sees tx_ready high
  task automatic send(input logic [7:0] v);
    @(posedge core_clk);
    tx_valid <= 1'b1;
    tx_byte <= v;
    n = 0;
    do begin @(posedge core_clk); n++; end while (tx_ready !== 1'b1 && n < 200);
    tx_valid <= 1'b0;
  endtask : send
  // leading edge skips a stale rx_valid from the previous take
  task automatic get_rx(input logic [7:0] x);
    n = 0;
    do begin @(posedge core_clk); n++; end while (rx_valid !== 1'b1 && n < 200);
    chk("rx_byte", rx_byte, x);
    rx_ready <= 1'b1;
    @(posedge core_clk);
    rx_ready <= 1'b0;
  endtask : get_rx
  // hang guard, a few hundred cycles expected
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    {core_clk, mode_cmd_valid, is_channel_b, baud_tick, usb_suspended, tx_valid, rx_ready, send_now_req} = '0;
    {reset, remote_wake_en} = 2'h3;
    {mode_cmd, dir_mask, tx_byte, drive_value, drive_enable, base_mode} = '0;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    // every command, last one refused on channel b opto
    for (int k = 0; k < 5; k++) begin
      dir_mask <= 8'($random(seed));
      is_channel_b <= (k == 4);
      base_mode <= (k == 4) ? `BBP_BASE_OPTO : `BBP_BASE_FIFO;
      set_mode(cmds[k]);
      chk("async_active", async_active, cmds[k] == `BBP_CMD_ASYNC && k != 4);
      chk("sync_active", sync_active, cmds[k] == `BBP_CMD_SYNC);
      e = ((cmds[k] == `BBP_CMD_ASYNC || cmds[k] == `BBP_CMD_SYNC) && k != 4) ? dir_mask : 8'h00;
      chk("bus_oe", bbp_link_if_i.bus_oe, e);
    end
    $display("test modes done");
    is_channel_b <= 1'b0;
    b = 8'($random(seed));
    dir_mask <= b;
    drive_enable <= ~b & 8'($random(seed));
    drive_value <= 8'($random(seed));
    set_mode(`BBP_CMD_ASYNC);
    prev = 8'hff;
    // async bytes, alternating fifo and uart base to move the strobe pair
    for (int k = 0; k < 6; k++) begin
      base_mode <= (k % 2) ? `BBP_BASE_UART : `BBP_BASE_FIFO;
      b = (k == 0) ? 8'h00 : 8'($random(seed));
      send(b);
      repeat (40) @(posedge core_clk); // ticks over a microsecond apart
      chk("bus_hold", bbp_link_if_i.bus_out, prev);
      baud_tick <= 1'b1;
      @(posedge core_clk);
      baud_tick <= 1'b0;
      {sa, sb} = 2'h0;
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
        sa |= !bbp_link_if_i.wr_strobe_a_n;
        sb |= !bbp_link_if_i.wr_strobe_b_n;
      end while (captured_valid !== 1'b1 && n < 100);
      chk("captured", captured_byte, lvl(b, dir_mask, drive_value, drive_enable));
      chk("pair_a", sa, !(k % 2));
      chk("pair_b", sb, 8'(k % 2));
      prev = b;
    end
    $display("test async done");
    // mid-run reset brings data back to all ones
    reset <= 1'b1;
    base_mode <= `BBP_BASE_FIFO;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    set_mode(`BBP_CMD_SYNC);
    prev = 8'hff;
    for (int k = 0; k < 5; k++) begin
      b = (k == 4) ? prev : 8'($random(seed));
      send(b);
      if (k == 2) begin
        repeat (20) @(posedge core_clk);
        chk("sync_stall", bbp_link_if_i.bus_out, prev);
      end
      if (k > 0) get_rx(e);
      e = lvl(prev, dir_mask, drive_value, drive_enable);
      prev = b;
    end
    get_rx(e);
    repeat (20) @(posedge core_clk);
    chk("sync_bus", bbp_link_if_i.bus_out, prev);
    $display("test sync done");
    // wake strobe suspended, running, then suspended with remote wake off
    for (int k = 0; k < 3; k++) begin
      usb_suspended <= (k != 1);
      remote_wake_en <= (k != 2);
      repeat (6) @(posedge core_clk);
      chk("suspended", suspended, (k != 1));
      send_now_req <= 1'b1;
      @(posedge core_clk);
      send_now_req <= 1'b0;
      {sa, sb} = 2'h0;
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
        sa |= resume_req;
        sb |= flush_req;
      end while (!(sa | sb) && n < 20);
      chk("resume_req", sa, (k == 0));
      chk("flush_req", sb, (k == 1));
    end
    $display("test wake done");
    stop_test();
  end
endmodule : tb_bit_bang_parallel_port
`default_nettype wire
